// [pdv_pkg.sv]
// Shared constants and carriers for the receive delay-variation write control.
// Assumes a 32-bit classic Wishbone register bus and byte addressing.
package pdv_pkg;
   localparam int NUM_CHAN = 1023;
   localparam int CHAN_W = 10;
   localparam int TS_W = 32;
   localparam int PTR_W = 12;
   localparam int SAMP_W = 11;
   localparam int ADR_W = 8;
   // Register byte offsets.
   localparam logic [ADR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [ADR_W-1:0] REG_MAX_USED = 8'h04;
   localparam logic [ADR_W-1:0] REG_MAX_EXP = 8'h08;
   localparam logic [ADR_W-1:0] REG_UNDER_LEAD = 8'h0C;
   localparam logic [ADR_W-1:0] REG_OVER_LEAD = 8'h10;
   localparam logic [ADR_W-1:0] REG_INIT_LEAD = 8'h14;
   localparam logic [ADR_W-1:0] REG_DESIRED = 8'h18;
   localparam logic [ADR_W-1:0] REG_SLIP = 8'h1C;
   localparam logic [ADR_W-1:0] REG_MIN_DELTA = 8'h20;
   localparam logic [ADR_W-1:0] REG_MAX_DELTA = 8'h24;
   localparam logic [ADR_W-1:0] REG_LAST_TS = 8'h28;
   localparam logic [ADR_W-1:0] REG_EVENTS = 8'h2C;
   // Control register field positions.
   localparam int CTL_INH_INC = 0;
   localparam int CTL_INH_DEC = 1;
   localparam int CTL_EXT_RSV = 2;
   localparam int CTL_RST_ONCE = 3;
   localparam int CTL_RST_MARK = 4;
   localparam int CTL_RST_LOSS = 5;
   localparam int CTL_RST_ALWAYS = 6;
   localparam int CTL_DIAG_CLR = 7;
   localparam int CTL_LOSS_LO = 8;
   localparam int CTL_W = 11;
   localparam int LOSS_CODE_W = 3;
   // Loss threshold for code 000, in frames; each code step doubles it.
   localparam logic [TS_W-1:0] LOSS_BASE_FRAMES = 32'h0000_0010;
   // Reset values.
   localparam logic [CTL_W-1:0] CTRL_RST = 11'h000;
   localparam logic [PTR_W-1:0] MAX_USED_RST = 12'h0EF;
   localparam logic [SAMP_W-1:0] MAX_EXP_RST = 11'h0A0;
   localparam logic [PTR_W-1:0] LEAD_RST = 12'h008;

   typedef struct packed {
      logic [CHAN_W-1:0] chan;
      logic [TS_W-1:0] rts;
      logic [SAMP_W-1:0] units;
      logic [1:0] bps_shift;
      logic marker;
   } pkt_t;

   typedef struct packed {
      logic [CHAN_W-1:0] chan;
      logic [PTR_W-1:0] ptr;
      logic [SAMP_W+2:0] samples;
      logic underrun;
      logic overrun;
      logic first;
      logic slip_reset;
   } wr_t;

   typedef struct packed {
      logic seen;
      logic [TS_W-1:0] next_rts;
   } chan_rec_t;
endpackage

// [chan_state_mem.sv]
// Per-channel record memory with registered read data.
// Assumes one read and one write per cycle at most; valid bits clear on reset.
`timescale 1ns/10ps
module chan_state_mem
   import pdv_pkg::*;
#(
   parameter int DEPTH = NUM_CHAN
) (
   input wire logic clk_i, // System clock.
   input wire logic rst_i, // Synchronous reset, active high.
   input wire logic rd_en_i, // Read strobe.
   input wire logic [CHAN_W-1:0] rd_addr_i, // Read channel.
   output chan_rec_t rd_data_o, // Record, valid the cycle after the strobe.
   input wire logic wr_en_i, // Write strobe.
   input wire logic [CHAN_W-1:0] wr_addr_i, // Write channel.
   input wire chan_rec_t wr_data_i // Record to store.
);
   logic [TS_W-1:0] ts_mem [DEPTH];
   logic [DEPTH-1:0] seen;
   logic [DEPTH-1:0] next_seen;
   chan_rec_t next_rd;

   // Only the seen bits need a reset; timestamps are ignored until seen is set.
   for (genvar g = 0; g < DEPTH; g++) begin : g_seen
      assign next_seen[g] = (wr_en_i && wr_addr_i == CHAN_W'(g)) ? wr_data_i.seen : seen[g];
   end

   always_comb begin
      next_rd = rd_data_o;
      if (rd_en_i) begin
         next_rd.seen = (rd_addr_i < CHAN_W'(DEPTH)) ? seen[rd_addr_i] : 1'b0;
         next_rd.next_rts = ts_mem[rd_addr_i];
      end
   end

   always_ff @(posedge clk_i) begin
      if (wr_en_i) begin
         ts_mem[wr_addr_i] <= wr_data_i.next_rts;
      end
      if (rst_i) begin
         seen <= '0;
         rd_data_o <= '0;
      end else begin
         seen <= next_seen;
         rd_data_o <= next_rd;
      end
   end
endmodule

// [delta_range.sv]
// Running minimum and maximum of signed remote-to-local deltas.
// Assumes software restarts it with a one-cycle clear pulse.
`timescale 1ns/10ps
module delta_range
   import pdv_pkg::*;
(
   input wire logic clk_i, // System clock.
   input wire logic rst_i, // Synchronous reset, active high.
   input wire logic clr_i, // Restart observation.
   input wire logic upd_i, // New delta present.
   input wire logic [TS_W-1:0] delta_i, // Signed delta.
   output logic [TS_W-1:0] min_o, // Smallest delta seen.
   output logic [TS_W-1:0] max_o // Largest delta seen.
);
   logic any;
   logic next_any;
   logic [TS_W-1:0] next_min;
   logic [TS_W-1:0] next_max;

   // The first delta after a restart seeds both ends; a new sample beats a clear.
   always_comb begin
      next_any = clr_i ? 1'b0 : any;
      next_min = min_o;
      next_max = max_o;
      if (upd_i) begin
         next_any = 1'b1;
         if (!any || clr_i || $signed(delta_i) < $signed(min_o)) begin
            next_min = delta_i;
         end
         if (!any || clr_i || $signed(delta_i) > $signed(max_o)) begin
            next_max = delta_i;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         any <= 1'b0;
         min_o <= '0;
         max_o <= '0;
      end else begin
         any <= next_any;
         min_o <= next_min;
         max_o <= next_max;
      end
   end
endmodule

// [pdv_write_ctrl.sv]
// Receive delay-variation write control: places packets into a channel buffer.
// Assumes packets arrive already parsed and a TDM read pointer and bus timestamp.
// Behaviour
// - Write position of each packet follows its remote timestamp.
// - Compressed payload units are converted to samples before any delay processing.
// - Payload length variation up to the maximum expected size is not a delay error.
// - Window length is maximum used samples minus maximum expected plus one; 80 by default.
// - Underrun moves the write pointer to read pointer plus underrun lead.
// - Overrun moves the write pointer to read pointer plus overrun lead.
// - The first packet of a channel is placed at the initial lead.
// - Every slip updates the slip offset by the samples slipped.
// - Minimum and maximum delta seen are tracked for diagnosis.
// - Reset-once clears the slip offset on the next packet.
// - Reset-on-marker clears the slip offset on the next marked packet.
// - Reset-on-loss clears the slip offset after a gap at the threshold.
// - Always-reset writes at the desired delta plus the slip offset and freezes the offset.
// - Inhibit-increment keeps the offset on overruns; only the event is reported.
// - Inhibit-decrement keeps the offset on underruns; only the event is reported.
// - The bus timestamp at the last processed packet is recorded.
// - All channels share one absorption structure and slip offset.
// - Slip offset is signed: overruns add, underruns subtract, they cancel.
// - Each delta is remote timestamp minus local bus timestamp.
// - Loss threshold code selects 16 frames doubling up to 2048 frames.
// - Each reset request bit clears itself once its reset is applied.
//
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
module pdv_write_ctrl
   import pdv_pkg::*;
#(
   parameter int CHANNELS = NUM_CHAN
) (
   input wire logic clk_i, // System clock, 100 MHz.
   input wire logic rst_i, // Synchronous reset, active high.
   input wire logic cyc_i, // Wishbone cycle.
   input wire logic stb_i, // Wishbone strobe.
   input wire logic we_i, // Wishbone write enable.
   input wire logic [ADR_W-1:0] adr_i, // Wishbone byte address.
   input wire logic [3:0] sel_i, // Wishbone byte lanes.
   input wire logic [31:0] dat_i, // Wishbone write data.
   output logic [31:0] dat_o, // Wishbone read data.
   output logic ack_o, // Wishbone acknowledge.
   input wire logic pkt_valid_i, // Parsed packet offered.
   input wire pkt_t pkt_i, // Packet descriptor.
   output logic pkt_ready_o, // Packet taken when high with valid.
   input wire logic [PTR_W-1:0] rd_ptr_i, // TDM read pointer.
   input wire logic [TS_W-1:0] bus_ts_i, // Local bus timestamp.
   output logic wr_valid_o, // Write placement pulse.
   output wr_t wr_o // Write placement.
);
   typedef enum logic {S_IDLE, S_CALC} state_t;

   state_t state, next_state;
   pkt_t pkt, next_pkt;
   logic next_ready;
   logic next_wr_valid;
   wr_t next_wr;
   chan_rec_t rec, mem_wdata;
   logic mem_we;
   logic [CTL_W-1:0] ctrl, next_ctrl;
   logic [PTR_W-1:0] max_used, next_max_used;
   logic [SAMP_W-1:0] max_exp, next_max_exp;
   logic [PTR_W-1:0] under_lead, next_under_lead;
   logic [PTR_W-1:0] over_lead, next_over_lead;
   logic [PTR_W-1:0] init_lead, next_init_lead;
   logic [TS_W-1:0] desired, next_desired;
   logic [TS_W-1:0] slip, next_slip;
   logic [TS_W-1:0] last_ts, next_last_ts;
   logic [15:0] under_cnt, next_under_cnt;
   logic [15:0] over_cnt, next_over_cnt;
   logic [31:0] next_dat;
   logic next_ack;
   logic [TS_W-1:0] min_delta, max_delta;
   logic [SAMP_W+2:0] samples;
   logic [TS_W-1:0] delta, gap, base_slip, lead, new_lead, slip_calc, over_thr;
   logic loss_hit, rst_req, is_under, is_over, diag_clr;
   logic bus_wr;

   // Merge one bus write into a register under its byte lanes.
   function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = d[8*b +: 8];
         end
      end
      return r;
   endfunction

   chan_state_mem #(.DEPTH(CHANNELS)) u_mem (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .rd_en_i(pkt_valid_i && pkt_ready_o),
      .rd_addr_i(pkt_i.chan),
      .rd_data_o(rec),
      .wr_en_i(mem_we),
      .wr_addr_i(pkt.chan),
      .wr_data_i(mem_wdata)
   );

   delta_range u_range (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .clr_i(diag_clr),
      .upd_i(state == S_CALC),
      .delta_i(delta),
      .min_o(min_delta),
      .max_o(max_delta)
   );

   // Placement arithmetic for the packet held in the calculation state.
   always_comb begin
      samples = (SAMP_W+3)'(pkt.units) << pkt.bps_shift;
      delta = pkt.rts - bus_ts_i;
      gap = pkt.rts - rec.next_rts;
      loss_hit = rec.seen && ctrl[CTL_RST_LOSS] && !gap[TS_W-1]
         && gap >= (LOSS_BASE_FRAMES << ctrl[CTL_LOSS_LO +: LOSS_CODE_W]);
      rst_req = ctrl[CTL_RST_ONCE] || (ctrl[CTL_RST_MARK] && pkt.marker) || loss_hit;
      base_slip = rst_req ? '0 : slip;
      lead = delta - desired - base_slip;
      // Threshold holds the worst-case payload back so size changes do not slip.
      over_thr = TS_W'(max_used) - TS_W'(max_exp) + TS_W'(1);
      is_under = rec.seen && lead[TS_W-1];
      is_over = rec.seen && !lead[TS_W-1] && $signed(lead) > $signed(over_thr);
      new_lead = lead;
      slip_calc = base_slip;
      if (!rec.seen) begin
         new_lead = TS_W'(init_lead);
         slip_calc = delta - desired - TS_W'(init_lead);
      end else if (ctrl[CTL_RST_ALWAYS]) begin
         new_lead = lead;
      end else if (is_under) begin
         new_lead = TS_W'(under_lead);
         if (!ctrl[CTL_INH_DEC]) begin
            slip_calc = base_slip + lead - TS_W'(under_lead);
         end
      end else if (is_over) begin
         new_lead = TS_W'(over_lead);
         if (!ctrl[CTL_INH_INC]) begin
            slip_calc = base_slip + lead - TS_W'(over_lead);
         end
      end
      mem_we = (state == S_CALC);
      mem_wdata.seen = 1'b1;
      mem_wdata.next_rts = pkt.rts + TS_W'(samples);
   end

   // Packet handshake and placement output.
   always_comb begin
      next_state = state;
      next_pkt = pkt;
      next_wr_valid = 1'b0;
      next_wr = wr_o;
      case (state)
         S_IDLE: begin
            if (pkt_valid_i && pkt_ready_o) begin
               next_pkt = pkt_i;
               next_state = S_CALC;
            end
         end
         S_CALC: begin
            next_wr_valid = 1'b1;
            next_wr.chan = pkt.chan;
            next_wr.ptr = rd_ptr_i + new_lead[PTR_W-1:0];
            next_wr.samples = samples;
            next_wr.underrun = is_under;
            next_wr.overrun = is_over;
            next_wr.first = !rec.seen;
            next_wr.slip_reset = rst_req && rec.seen;
            next_state = S_IDLE;
         end
         default: next_state = S_IDLE;
      endcase
      next_ready = (next_state == S_IDLE);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= S_IDLE;
         pkt <= '0;
         pkt_ready_o <= 1'b0;
         wr_valid_o <= 1'b0;
         wr_o <= '0;
      end else begin
         state <= next_state;
         pkt <= next_pkt;
         pkt_ready_o <= next_ready;
         wr_valid_o <= next_wr_valid;
         wr_o <= next_wr;
      end
   end

   // Register file: a write lands at the edge where ack is seen high.
   always_comb begin
      bus_wr = cyc_i && stb_i && we_i && ack_o;
      next_ack = cyc_i && stb_i && !ack_o;
      next_ctrl = ctrl;
      next_max_used = max_used;
      next_max_exp = max_exp;
      next_under_lead = under_lead;
      next_over_lead = over_lead;
      next_init_lead = init_lead;
      next_desired = desired;
      next_slip = slip;
      next_last_ts = last_ts;
      next_under_cnt = under_cnt;
      next_over_cnt = over_cnt;
      diag_clr = 1'b0;
      // Hardware first, so that a software write in the same cycle overrides it.
      if (state == S_CALC) begin
         next_last_ts = bus_ts_i;
         next_slip = slip_calc;
         if (rec.seen) begin
            next_ctrl[CTL_RST_ONCE] = 1'b0;
            if (pkt.marker) begin
               next_ctrl[CTL_RST_MARK] = 1'b0;
            end
            if (loss_hit) begin
               next_ctrl[CTL_RST_LOSS] = 1'b0;
            end
         end
         next_under_cnt = under_cnt + 16'(is_under);
         next_over_cnt = over_cnt + 16'(is_over);
      end
      if (bus_wr) begin
         case (adr_i)
            REG_CTRL: begin
               next_ctrl = CTL_W'(lanes(32'(ctrl), dat_i, sel_i));
               diag_clr = sel_i[0] && dat_i[CTL_DIAG_CLR];
               next_ctrl[CTL_DIAG_CLR] = 1'b0;
            end
            REG_MAX_USED: next_max_used = PTR_W'(lanes(32'(max_used), dat_i, sel_i));
            REG_MAX_EXP: next_max_exp = SAMP_W'(lanes(32'(max_exp), dat_i, sel_i));
            REG_UNDER_LEAD: next_under_lead = PTR_W'(lanes(32'(under_lead), dat_i, sel_i));
            REG_OVER_LEAD: next_over_lead = PTR_W'(lanes(32'(over_lead), dat_i, sel_i));
            REG_INIT_LEAD: next_init_lead = PTR_W'(lanes(32'(init_lead), dat_i, sel_i));
            REG_DESIRED: next_desired = lanes(desired, dat_i, sel_i);
            REG_SLIP: next_slip = lanes(slip, dat_i, sel_i);
            default: next_ack = next_ack;
         endcase
      end
      case (adr_i)
         REG_CTRL: next_dat = 32'(ctrl);
         REG_MAX_USED: next_dat = 32'(max_used);
         REG_MAX_EXP: next_dat = 32'(max_exp);
         REG_UNDER_LEAD: next_dat = 32'(under_lead);
         REG_OVER_LEAD: next_dat = 32'(over_lead);
         REG_INIT_LEAD: next_dat = 32'(init_lead);
         REG_DESIRED: next_dat = desired;
         REG_SLIP: next_dat = slip;
         REG_MIN_DELTA: next_dat = min_delta;
         REG_MAX_DELTA: next_dat = max_delta;
         REG_LAST_TS: next_dat = last_ts;
         REG_EVENTS: next_dat = {over_cnt, under_cnt};
         default: next_dat = 32'h0000_0000;
      endcase
      if (!next_ack) begin
         next_dat = 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= CTRL_RST;
         max_used <= MAX_USED_RST;
         max_exp <= MAX_EXP_RST;
         under_lead <= LEAD_RST;
         over_lead <= LEAD_RST;
         init_lead <= LEAD_RST;
         desired <= '0;
         slip <= '0;
         last_ts <= '0;
         under_cnt <= '0;
         over_cnt <= '0;
         ack_o <= 1'b0;
         dat_o <= '0;
      end else begin
         ctrl <= next_ctrl;
         max_used <= next_max_used;
         max_exp <= next_max_exp;
         under_lead <= next_under_lead;
         over_lead <= next_over_lead;
         init_lead <= next_init_lead;
         desired <= next_desired;
         slip <= next_slip;
         last_ts <= next_last_ts;
         under_cnt <= next_under_cnt;
         over_cnt <= next_over_cnt;
         ack_o <= next_ack;
         dat_o <= next_dat;
      end
   end
endmodule

// [pdv_write_ctrl_sva.sv]
// Assertion checker for the delay-variation write control, bound to its ports.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/10ps
module pdv_write_ctrl_sva
   import pdv_pkg::*;
(
   input wire logic clk_i, // System clock.
   input wire logic rst_i, // Synchronous reset.
   input wire logic cyc_i, // Bus cycle.
   input wire logic stb_i, // Bus strobe.
   input wire logic [31:0] dat_o, // Read data.
   input wire logic ack_o, // Acknowledge.
   input wire logic pkt_valid_i, // Packet offered.
   input wire pkt_t pkt_i, // Packet descriptor.
   input wire logic pkt_ready_o, // Packet ready.
   input wire logic wr_valid_o, // Placement pulse.
   input wire wr_t wr_o // Placement.
);
   logic take;
   // A packet is taken on an edge where both handshake sides are high.
   assign take = pkt_valid_i & pkt_ready_o;
   default clocking dcb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("bus request not acknowledged one cycle later");
   AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
      else $error("acknowledge held longer than one cycle");
   AST_DAT_IDLE: assert property (!ack_o |-> dat_o == 32'h0000_0000)
      else $error("read data not zero outside acknowledge");
   // Reset must silence every handshake output, so this one ignores the default disable.
   AST_RESET_QUIET: assert property (disable iff (1'b0)
      rst_i |=> !ack_o && !wr_valid_o && !pkt_ready_o)
      else $error("outputs active after a reset edge");
   AST_READY: assert property (take |=> !pkt_ready_o ##1 pkt_ready_o)
      else $error("ready did not drop for exactly the calc cycle");
   AST_PLACE_LAT: assert property (take |=> !wr_valid_o ##1 wr_valid_o)
      else $error("placement not two cycles after take");
   AST_PLACE_CAUSE: assert property (wr_valid_o |-> $past(take, 2))
      else $error("placement without a packet taken");
   AST_SAMPLES: assert property (wr_valid_o |->
      wr_o.samples == ({3'h0, $past(pkt_i.units, 2)} << $past(pkt_i.bps_shift, 2)))
      else $error("sample count not units scaled by shift");
   AST_CHAN: assert property (wr_valid_o |-> wr_o.chan == $past(pkt_i.chan, 2))
      else $error("placement channel differs from packet");
   AST_SLIP_KIND: assert property (wr_valid_o |-> !(wr_o.underrun && wr_o.overrun))
      else $error("underrun and overrun flagged together");
   // The past term keeps the reset clearing of the placement out of the hold check.
   AST_HOLD: assert property (!wr_valid_o && !$past(rst_i) |-> $stable(wr_o))
      else $error("placement changed without a pulse");
endmodule

// [pdv_pkt_source.sv]
// Partner model: disassembly path and TDM side feeding the write control.
// Assumes the bench calls send from one process, one packet at a time.
`timescale 1ns/10ps
module pdv_pkt_source
   import pdv_pkg::*;
(
   input wire logic clk_i, // System clock.
   input wire logic pkt_ready_i, // Design takes the packet when high.
   output logic pkt_valid_o, // Packet offered.
   output pkt_t pkt_o, // Packet descriptor.
   output logic [PTR_W-1:0] rd_ptr_o, // TDM read pointer, held at 100.
   output logic [TS_W-1:0] bus_ts_o // Local bus timestamp.
);
   // The read pointer stays still so every expected position is rd plus a lead.
   initial begin
      pkt_valid_o = 1'b0;
      pkt_o = '0;
      rd_ptr_o = 12'h064;
      bus_ts_o = 32'h000003E8;
   end
   // Hold the offer until taken; the released descriptor shows inverted bits.
   task automatic send(input pkt_t p, input logic [TS_W-1:0] ts, output logic ok);
      int n;
      n = 0;
      @(posedge clk_i);
      pkt_valid_o <= 1'b1;
      pkt_o <= p;
      bus_ts_o <= ts;
      do begin
         @(posedge clk_i);
         n++;
      end while (pkt_ready_i !== 1'b1 && n < 50);
      ok = (pkt_ready_i === 1'b1);
      pkt_valid_o <= 1'b0;
      pkt_o <= ~p;
   endtask
endmodule

// [pdv_write_ctrl_tb.sv]
// Self-checking bench for the delay-variation write control.
// Assumes the packet source model and the bound checker beside the design.
`timescale 1ns/10ps
module pdv_write_ctrl_tb;
   import pdv_pkg::*;
   typedef struct packed {
      logic [CHAN_W-1:0] chan;
      logic [TS_W-1:0] rts;
      logic [TS_W-1:0] ts;
      logic [SAMP_W-1:0] units;
      logic [1:0] sh;
      logic mk;
      logic [PTR_W-1:0] ptr;
      logic [3:0] fl;
      logic [31:0] slip;
   } row_t;
   logic clk, rst, cyc, stb, we, ack, pkt_valid, pkt_ready, wr_valid;
   logic [ADR_W-1:0] adr;
   logic [31:0] dat_w, dat_r, q, d, mn, mx;
   logic [PTR_W-1:0] rd_ptr;
   logic [TS_W-1:0] bus_ts;
   logic [2:0] cc;
   pkt_t pkt;
   wr_t wr;
   row_t r;
   row_t rows [7];
   logic [ADR_W-1:0] ra [6];
   logic [31:0] rv [6];
   int n_mismatch = 0;
   int checks_done = 0;
   pdv_write_ctrl dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(4'hF), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack),
      .pkt_valid_i(pkt_valid), .pkt_i(pkt), .pkt_ready_o(pkt_ready), .rd_ptr_i(rd_ptr),
      .bus_ts_i(bus_ts), .wr_valid_o(wr_valid), .wr_o(wr));
   pdv_pkt_source src (.clk_i(clk), .pkt_ready_i(pkt_ready), .pkt_valid_o(pkt_valid),
      .pkt_o(pkt), .rd_ptr_o(rd_ptr), .bus_ts_o(bus_ts));
   // Free-running 100 MHz clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic done(input string s);
      $display("test %s finished at %0t", s, $time);
   endtask
   // One classic Wishbone cycle; the request is held until ack is sampled high.
   task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] dv,
                     output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= dv;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) n_mismatch++;
      rd = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   // Send one packet, wait for its placement, then compare it and the slip offset.
   task automatic place(input row_t x);
      pkt_t p;
      logic ok;
      logic [31:0] s;
      int n;
      p = '{chan: x.chan, rts: x.rts, units: x.units, bps_shift: x.sh, marker: x.mk};
      src.send(p, x.ts, ok);
      if (ok !== 1'b1) n_mismatch++;
      n = 0;
      while (wr_valid !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      chk(32'(wr.ptr), 32'(x.ptr));
      chk(32'({wr.underrun, wr.overrun, wr.first, wr.slip_reset}), 32'(x.fl));
      chk(32'(wr.samples), 32'({3'h0, x.units} << x.sh));
      wb(1'b0, REG_SLIP, 32'h0, s);
      chk(s, x.slip);
   endtask
   task automatic pk(input logic [31:0] t, input logic m, input logic [11:0] pt,
                     input logic [3:0] f, input logic [31:0] s);
      row_t y;
      y = '{10'h001, t, 32'h000003E8, 11'h014, 2'h0, m, pt, f, s};
      place(y);
   endtask
   // Watchdog well beyond the few hundred cycles the sequence needs.
   initial begin
      #200000;
      n_mismatch++;
      close_out();
   end
   // Main sequence: reset, register defaults, table rows, then awkward cases.
   initial begin
      rst = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      dat_w = 32'h0;
      rows = '{
         '{10'h001, 32'h0000041A, 32'h000003E8, 11'h014, 2'h0, 1'b0, 12'h06C, 4'h2, 32'h2A},
         '{10'h002, 32'h00000424, 32'h000003E8, 11'h00A, 2'h1, 1'b0, 12'h06C, 4'h2, 32'h34},
         '{10'h001, 32'h0000043A, 32'h000003E8, 11'h005, 2'h2, 1'b0, 12'h082, 4'h0, 32'h34},
         '{10'h001, 32'h00000417, 32'h000003E8, 11'h014, 2'h0, 1'b0, 12'h06C, 4'h8, 32'h27},
         '{10'h001, 32'h00000460, 32'h000003E8, 11'h014, 2'h0, 1'b0, 12'h06C, 4'h4, 32'h70},
         '{10'h001, 32'h000004A8, 32'h000003E8, 11'h014, 2'h0, 1'b0, 12'h0B4, 4'h0, 32'h70},
         '{10'h001, 32'h00000840, 32'h000007D0, 11'h014, 2'h0, 1'b0, 12'h064, 4'h0, 32'h70}};
      ra = '{REG_CTRL, REG_MAX_USED, REG_MAX_EXP, REG_UNDER_LEAD, REG_INIT_LEAD, 8'h3C};
      rv = '{32'h0, 32'hEF, 32'hA0, 32'h8, 32'h8, 32'h0};
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         wb(1'b0, ra[i], 32'h0, q);
         chk(q, rv[i]);
      end
      done("defaults");
      // Software setup: zero desired delta, window of 80 with a 160-sample payload.
      wb(1'b1, REG_DESIRED, 32'h0, q);
      wb(1'b1, REG_MAX_USED, 32'(80 + 160 - 1), q);
      for (int i = 0; i < 7; i++) begin
         place(rows[i]);
         d = rows[i].rts - rows[i].ts;
         if (i == 0 || $signed(d) < $signed(mn)) mn = d;
         if (i == 0 || $signed(d) > $signed(mx)) mx = d;
      end
      wb(1'b0, REG_MIN_DELTA, 32'h0, q);
      chk(q, mn);
      wb(1'b0, REG_MAX_DELTA, 32'h0, q);
      chk(q, mx);
      wb(1'b0, REG_LAST_TS, 32'h0, q);
      chk(q, rows[6].ts);
      done("rows");
      wb(1'b1, REG_CTRL, 32'h1, q);
      pk(32'h000004B2, 1'b0, 12'h06C, 4'h4, 32'h70);
      wb(1'b1, REG_CTRL, 32'h2, q);
      pk(32'h0000044C, 1'b0, 12'h06C, 4'h8, 32'h70);
      wb(1'b1, REG_SLIP, 32'h5C, q);
      done("inhibit");
      wb(1'b1, REG_CTRL, 32'h8, q);
      pk(32'h00000406, 1'b0, 12'h082, 4'h1, 32'h0);
      wb(1'b0, REG_CTRL, 32'h0, q);
      chk(q, 32'h0);
      done("reset_once");
      wb(1'b1, REG_CTRL, 32'h10, q);
      wb(1'b1, REG_SLIP, 32'h14, q);
      pk(32'h00000406, 1'b0, 12'h06E, 4'h0, 32'h14);
      wb(1'b0, REG_CTRL, 32'h0, q);
      chk(q, 32'h10);
      pk(32'h00000406, 1'b1, 12'h082, 4'h1, 32'h0);
      wb(1'b0, REG_CTRL, 32'h0, q);
      chk(q, 32'h0);
      done("marker");
      wb(1'b1, REG_CTRL, 32'h40, q);
      wb(1'b1, REG_SLIP, 32'h5, q);
      pk(32'h000003E8, 1'b0, 12'h05F, 4'h8, 32'h5);
      done("always");
      wb(1'b1, REG_CTRL, 32'h0, q);
      wb(1'b1, REG_SLIP, 32'h0, q);
      r = '{10'h001, 32'h00001000, 32'h00000FF6, 11'h004, 2'h0, 1'b0, 12'h06E, 4'h0, 32'h0};
      place(r);
      for (int c = 0; c < 8; c++) begin
         cc = c[2:0];
         wb(1'b1, REG_CTRL, {21'h0, cc, 8'h20}, q);
         // A non-zero offset shows whether the gap really cleared it.
         wb(1'b1, REG_SLIP, 32'h3, q);
         for (int k = 0; k < 2; k++) begin
            r.rts = r.rts + 32'h4 + (32'h10 << cc) - 32'(1 - k);
            r.ts = r.rts - 32'hA;
            r.fl = 4'(k);
            r.ptr = 12'h06B + 12'(3 * k);
            r.slip = 32'(3 - 3 * k);
            place(r);
         end
         wb(1'b0, REG_CTRL, 32'h0, q);
         chk(q, {21'h0, cc, 8'h00});
      end
      done("loss");
      // Folding the offset into the desired delta must leave placement unchanged.
      wb(1'b1, REG_SLIP, 32'hC, q);
      pk(32'h000003FE, 1'b0, 12'h06E, 4'h0, 32'hC);
      wb(1'b1, REG_DESIRED, 32'hC, q);
      wb(1'b1, REG_SLIP, 32'h0, q);
      pk(32'h000003FE, 1'b0, 12'h06E, 4'h0, 32'h0);
      done("fold");
      // Mid-run reset: offset clears and every channel is new again.
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      wb(1'b0, REG_SLIP, 32'h0, q);
      chk(q, 32'h0);
      pk(32'h000003F2, 1'b0, 12'h06C, 4'h2, 32'h2);
      done("reset");
      close_out();
   end
endmodule
bind pdv_write_ctrl pdv_write_ctrl_sva sva_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .pkt_valid_i(pkt_valid_i), .pkt_i(pkt_i),
   .pkt_ready_o(pkt_ready_o), .wr_valid_o(wr_valid_o), .wr_o(wr_o));
